// *** src/cmt_pkg.sv ***
package cmt_pkg;

    // Register byte addresses on the 8-bit peripheral bus.
    localparam logic [15:0] ADDR_CTRL = 16'hFFB6;
    localparam logic [15:0] ADDR_FLAGS = 16'hFFB7;
    localparam logic [15:0] ADDR_CNT_HI = 16'hFFB8;
    localparam logic [15:0] ADDR_CNT_LO = 16'hFFB9;
    localparam logic [15:0] ADDR_CMP_HI = 16'hFFBA;
    localparam logic [15:0] ADDR_CMP_LO = 16'hFFBB;

    // Reset values.
    localparam logic [7:0] CNT_RESET = 8'h00;
    localparam logic [7:0] CMP_RESET = 8'hFF;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] BYTE_ONES = 8'hFF;

    // Read answers for the write-only control byte and unmapped addresses.
    localparam logic [7:0] CTRL_READ_VALUE = 8'hFF;
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

    // Field positions in timer_control.
    localparam int CTRL_UPPER_LEVEL = 7;
    localparam int CTRL_UPPER_SEL_MSB = 6;
    localparam int CTRL_UPPER_SEL_LO = 4;
    localparam int CTRL_LOWER_LEVEL = 3;
    localparam int CTRL_LOWER_SEL_MSB = 2;
    localparam int CTRL_LOWER_SEL_LO = 0;

    // Field positions in timer_flags_and_enables.
    localparam int FLG_UPPER_OVF = 7;
    localparam int FLG_UPPER_MATCH = 6;
    localparam int FLG_UPPER_OVIE = 5;
    localparam int FLG_UPPER_CLEAR = 4;
    localparam int FLG_LOWER_OVF = 3;
    localparam int FLG_LOWER_MATCH = 2;
    localparam int FLG_LOWER_OVIE = 1;
    localparam int FLG_LOWER_CLEAR = 0;
    localparam logic [7:0] FLG_STATUS_MASK = 8'hCC;

    // Internal clock selections in the two low bits of a clock-select field.
    localparam logic [1:0] SEL_DIV32 = 2'h0;
    localparam logic [1:0] SEL_DIV16 = 2'h1;
    localparam logic [1:0] SEL_DIV4 = 2'h2;
    localparam logic [1:0] SEL_DIV2 = 2'h3;

    // Prescaler taps: a divide-by-N tick fires when the low bits are all ones.
    localparam int PRE_WIDTH = 5;
    localparam logic [4:0] PRE_MASK_DIV2 = 5'h01;
    localparam logic [4:0] PRE_MASK_DIV4 = 5'h03;
    localparam logic [4:0] PRE_MASK_DIV16 = 5'h0F;
    localparam logic [4:0] PRE_MASK_DIV32 = 5'h1F;

    // One CPU bus access; rd and wr are one-cycle strobes.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } cmt_bus_req_s;

endpackage

// *** src/cmt_edge_sync.sv ***
`timescale 1ns/1ps
module cmt_edge_sync (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic pin_i,
    input wire logic rising_i,
    output logic pulse_o
);
    // Two-stage synchroniser; only the second stage is looked at.
    logic meta_ff;
    logic sync_ff;
    // Previous synchronised level for edge detection.
    logic last_ff;

    // Synchroniser chain.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            last_ff <= 1'b0;
        end else begin
            meta_ff <= pin_i;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    // One-cycle count enable on the chosen edge.
    // single-cycle edge pulse
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pulse_o <= 1'b0;
        end else if (rising_i) begin
            pulse_o <= sync_ff & ~last_ff;
        end else begin
            pulse_o <= ~sync_ff & last_ff;
        end
    end
endmodule

// *** src/cmt_half.sv ***
`timescale 1ns/1ps
module cmt_half (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic load_i,
    input wire logic [7:0] load_val_i,
    input wire logic clr_i,
    input wire logic inc_i,
    output logic [7:0] count_o
);
    import cmt_pkg::*;

    // One 8-bit counter half: CPU load beats clear, clear beats increment.
    // counter resets to zero
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count_o <= CNT_RESET;
        end else if (load_i) begin
            count_o <= load_val_i;
        end else if (clr_i) begin
            count_o <= CNT_RESET;
        end else if (inc_i) begin
            count_o <= count_o + 8'h01;
        end
    end
endmodule

// *** src/cmt_timer.sv ***
// Summary of operation
// - Wide counter is two cascaded byte counters.
// - Reset clears both counter halves.
// - Reset sets both compare bytes to ones.
// - Upper select MSB zero: cascade on overflow.
// - Wide wrap sets upper overflow, optional request.
// - Wide match sets upper match flag, request.
// - Upper select MSB one: two separate counters.
// - Byte wrap sets that half's overflow flag.
// - Byte match sets that half's match flag.
// - Wide clear on match only when enabled.
// - Byte clear on match only when enabled.
// - Compare match inverts the toggle pin.
// - Control bit 7 forces upper pin level.
// - Control bit 3 forces lower pin level.
// - Upper select picks prescaled system clock tap.
// - Lower select picks event pin or tap.
// - Event edge polarity comes from outside input.
// - Control is write-only, resets to zero.
// - Wide mode transfers use the byte latch.
// - Upper write latched; lower write commits both.
// - Upper counter read captures lower into latch.
// - Flags cleared by writing zero after one.
`timescale 1ns/1ps
module cmt_timer (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire cmt_pkg::cmt_bus_req_s bus_req_i,
    input wire logic event_count_pin_i,
    input wire logic event_edge_select_i,
    output logic [7:0] rdata_o,
    output logic upper_toggle_pin_o,
    output logic lower_toggle_pin_o,
    output logic upper_irq_request_o,
    output logic lower_irq_request_o
);
    import cmt_pkg::*;

    // Software-visible state.
    logic [7:0] ctrl_ff; // timer_control, never read back.
    logic [7:0] flags_ff; // timer_flags_and_enables.
    logic [7:0] armed_ff; // Flags that were read as one.
    logic [7:0] cmp_hi_ff; // compare_upper_byte.
    logic [7:0] cmp_lo_ff; // compare_lower_byte.
    logic [7:0] temp_ff; // Shared byte latch for wide transfers.
    logic [PRE_WIDTH-1:0] pre_ff; // Free-running prescaler.
    logic hi_eq_ff; // Equality seen last cycle, for match edges.
    logic lo_eq_ff;

    // Counter halves and event enable.
    logic [7:0] cnt_hi;
    logic [7:0] cnt_lo;
    logic ev_pulse;

    // Decoded strobes.
    logic wr_ctrl, wr_flags, wr_cnt_hi, wr_cnt_lo, wr_cmp_hi, wr_cmp_lo;
    logic rd_flags, rd_cnt_hi;
    logic mode8;
    logic lo_tick, hi_tick8;
    logic hi_inc, lo_inc, hi_clr, lo_clr, hi_ld, lo_ld;
    logic [7:0] hi_ld_val, lo_ld_val;
    logic wide_eq, hi_eq, lo_eq, hi_mev, lo_mev, hi_ov, lo_ov, lo_wrap;

    // Picks a prescaler tap; the tap is a one-cycle enable, not a clock.
    function automatic logic sel_tick(input logic [1:0] sel, input logic [PRE_WIDTH-1:0] pre);
        logic [PRE_WIDTH-1:0] mask;
        mask = PRE_MASK_DIV2;
        case (sel)
            SEL_DIV32: mask = PRE_MASK_DIV32;
            SEL_DIV16: mask = PRE_MASK_DIV16;
            SEL_DIV4: mask = PRE_MASK_DIV4;
            default: mask = PRE_MASK_DIV2;
        endcase
        sel_tick = ((pre & mask) == mask);
    endfunction

    // Address decode; an unmapped address is ignored on write.
    always_comb begin
        wr_ctrl = 1'b0;
        wr_flags = 1'b0;
        wr_cnt_hi = 1'b0;
        wr_cnt_lo = 1'b0;
        wr_cmp_hi = 1'b0;
        wr_cmp_lo = 1'b0;
        if (bus_req_i.addr == ADDR_CTRL) begin
            wr_ctrl = bus_req_i.wr;
        end else if (bus_req_i.addr == ADDR_FLAGS) begin
            wr_flags = bus_req_i.wr;
        end else if (bus_req_i.addr == ADDR_CNT_HI) begin
            wr_cnt_hi = bus_req_i.wr;
        end else if (bus_req_i.addr == ADDR_CNT_LO) begin
            wr_cnt_lo = bus_req_i.wr;
        end else if (bus_req_i.addr == ADDR_CMP_HI) begin
            wr_cmp_hi = bus_req_i.wr;
        end else if (bus_req_i.addr == ADDR_CMP_LO) begin
            wr_cmp_lo = bus_req_i.wr;
        end
    end
    assign rd_flags = bus_req_i.rd && (bus_req_i.addr == ADDR_FLAGS);
    assign rd_cnt_hi = bus_req_i.rd && (bus_req_i.addr == ADDR_CNT_HI);

    assign mode8 = ctrl_ff[CTRL_UPPER_SEL_MSB];

    // Free-running prescaler for the internal taps.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pre_ff <= '0;
        end else begin
            pre_ff <= pre_ff + 5'h01;
        end
    end

    cmt_edge_sync u_event (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .pin_i(event_count_pin_i),
        .rising_i(event_edge_select_i),
        .pulse_o(ev_pulse)
    );

    assign lo_tick = ctrl_ff[CTRL_LOWER_SEL_MSB]
        ? sel_tick(ctrl_ff[CTRL_LOWER_SEL_LO+1:CTRL_LOWER_SEL_LO], pre_ff) : ev_pulse;
    assign hi_tick8 = sel_tick(ctrl_ff[CTRL_UPPER_SEL_LO+1:CTRL_UPPER_SEL_LO], pre_ff);

    // Comparators run every cycle, not only on count ticks.
    // wide comparison
    assign wide_eq = ({cnt_hi, cnt_lo} == {cmp_hi_ff, cmp_lo_ff});
    assign hi_eq = mode8 ? (cnt_hi == cmp_hi_ff) : wide_eq;
    assign lo_eq = mode8 && (cnt_lo == cmp_lo_ff);
    // A match event is the first cycle of equality, so a slow tap toggles once.
    assign hi_mev = hi_eq && !hi_eq_ff;
    assign lo_mev = lo_eq && !lo_eq_ff;

    // Clear on the tick that would leave the matching value.
    // wide clear when enabled
    assign lo_clr = mode8 ? (flags_ff[FLG_LOWER_CLEAR] && lo_eq && lo_tick)
        : (flags_ff[FLG_UPPER_CLEAR] && wide_eq && lo_tick);
    assign hi_clr = mode8 ? (flags_ff[FLG_UPPER_CLEAR] && hi_eq && hi_tick8) : lo_clr;

    assign lo_inc = lo_tick;
    assign lo_wrap = lo_inc && (cnt_lo == BYTE_ONES);
    assign hi_inc = mode8 ? hi_tick8 : lo_wrap;

    assign hi_ov = hi_inc && !hi_clr && !hi_ld && (cnt_hi == BYTE_ONES);
    assign lo_ov = mode8 && lo_wrap && !lo_clr && !lo_ld;

    // CPU loads of the counter halves.
    // wide writes via latch
    assign hi_ld = mode8 ? wr_cnt_hi : wr_cnt_lo;
    assign hi_ld_val = mode8 ? bus_req_i.wdata : temp_ff;
    assign lo_ld = wr_cnt_lo;
    assign lo_ld_val = bus_req_i.wdata;

    cmt_half u_hi (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .load_i(hi_ld),
        .load_val_i(hi_ld_val),
        .clr_i(hi_clr),
        .inc_i(hi_inc),
        .count_o(cnt_hi)
    );

    cmt_half u_lo (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .load_i(lo_ld),
        .load_val_i(lo_ld_val),
        .clr_i(lo_clr),
        .inc_i(lo_inc),
        .count_o(cnt_lo)
    );

    // Control register; the mode takes effect on the next cycle.
    // write-only, resets to zero
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_ff <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_ff <= bus_req_i.wdata;
        end
    end

    // Compare bytes, direct in byte mode, paired through the latch otherwise.
    // compare resets to ones
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cmp_hi_ff <= CMP_RESET;
            cmp_lo_ff <= CMP_RESET;
        end else begin
            if (mode8 && wr_cmp_hi) begin
                cmp_hi_ff <= bus_req_i.wdata;
            end else if (!mode8 && wr_cmp_lo) begin
                cmp_hi_ff <= temp_ff;
            end
            if (wr_cmp_lo) begin
                cmp_lo_ff <= bus_req_i.wdata;
            end
        end
    end

    // Shared byte latch; only used in wide mode.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            temp_ff <= CNT_RESET;
        end else if (!mode8 && (wr_cnt_hi || wr_cmp_hi)) begin
            temp_ff <= bus_req_i.wdata;
        end else if (!mode8 && rd_cnt_hi) begin
            temp_ff <= cnt_lo;
        end
    end

    // Read data, registered; the answer appears one cycle after the strobe.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= UNMAPPED_READ_VALUE;
        end else if (bus_req_i.rd) begin
            if (bus_req_i.addr == ADDR_CTRL) begin
                rdata_o <= CTRL_READ_VALUE;
            end else if (bus_req_i.addr == ADDR_FLAGS) begin
                rdata_o <= flags_ff;
            end else if (bus_req_i.addr == ADDR_CNT_HI) begin
                rdata_o <= cnt_hi;
            end else if (bus_req_i.addr == ADDR_CNT_LO) begin
                rdata_o <= mode8 ? cnt_lo : temp_ff;
            end else if (bus_req_i.addr == ADDR_CMP_HI) begin
                rdata_o <= cmp_hi_ff;
            end else if (bus_req_i.addr == ADDR_CMP_LO) begin
                rdata_o <= cmp_lo_ff;
            end else begin
                rdata_o <= UNMAPPED_READ_VALUE;
            end
        end
    end

    // Remembers which flags software has seen set; a write disarms them.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            armed_ff <= FLAGS_RESET;
        end else if (rd_flags) begin
            armed_ff <= flags_ff & FLG_STATUS_MASK;
        end else if (wr_flags) begin
            armed_ff <= FLAGS_RESET;
        end
    end

    // Status flags and enables; a hardware set beats a software clear.
    // clear only after read
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            flags_ff <= FLAGS_RESET;
        end else begin
            if (wr_flags) begin
                flags_ff <= (bus_req_i.wdata & ~FLG_STATUS_MASK)
                    | (flags_ff & FLG_STATUS_MASK & ~(armed_ff & ~bus_req_i.wdata));
            end
            if (hi_ov) begin
                flags_ff[FLG_UPPER_OVF] <= 1'b1;
            end
            if (hi_mev) begin
                flags_ff[FLG_UPPER_MATCH] <= 1'b1;
            end
            if (lo_ov) begin
                flags_ff[FLG_LOWER_OVF] <= 1'b1;
            end
            if (lo_mev) begin
                flags_ff[FLG_LOWER_MATCH] <= 1'b1;
            end
        end
    end

    // Edge memory for match events.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hi_eq_ff <= 1'b0;
            lo_eq_ff <= 1'b0;
        end else begin
            hi_eq_ff <= hi_eq;
            lo_eq_ff <= lo_eq;
        end
    end

    // Request pulses into the outside request latches; match needs no enable.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            upper_irq_request_o <= 1'b0;
            lower_irq_request_o <= 1'b0;
        end else begin
            upper_irq_request_o <= (hi_ov && flags_ff[FLG_UPPER_OVIE]) || hi_mev;
            lower_irq_request_o <= (lo_ov && flags_ff[FLG_LOWER_OVIE]) || lo_mev;
        end
    end

    // Toggle pins; a control write wins over a match in the same cycle.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            upper_toggle_pin_o <= 1'b0;
            lower_toggle_pin_o <= 1'b0;
        end else if (wr_ctrl) begin
            upper_toggle_pin_o <= bus_req_i.wdata[CTRL_UPPER_LEVEL];
            lower_toggle_pin_o <= bus_req_i.wdata[CTRL_LOWER_LEVEL];
        end else begin
            upper_toggle_pin_o <= upper_toggle_pin_o ^ hi_mev;
            lower_toggle_pin_o <= lower_toggle_pin_o ^ lo_mev;
        end
    end

    a_upper_level_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        wr_ctrl |=> upper_toggle_pin_o == $past(bus_req_i.wdata[CTRL_UPPER_LEVEL]))
        else $error("upper pin level not forced");
    a_lower_level_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        wr_ctrl |=> lower_toggle_pin_o == $past(bus_req_i.wdata[CTRL_LOWER_LEVEL]))
        else $error("lower pin level not forced");
    a_match_toggles_pin: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (hi_mev && !wr_ctrl) |=> upper_toggle_pin_o != $past(upper_toggle_pin_o))
        else $error("upper pin did not toggle on match");
    a_wide_match_request: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (!mode8 && hi_mev) |=> upper_irq_request_o && flags_ff[FLG_UPPER_MATCH])
        else $error("wide match missed flag or request");
    a_wide_ovf_flag: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (!mode8 && hi_ov) |=> flags_ff[FLG_UPPER_OVF] && cnt_hi == 8'h00)
        else $error("wide overflow not flagged");
    a_lower_ovf_request: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (lo_ov && flags_ff[FLG_LOWER_OVIE]) |=> lower_irq_request_o && flags_ff[FLG_LOWER_OVF])
        else $error("lower overflow request missing");
    a_wide_clear_match: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (!mode8 && lo_clr && !wr_cnt_lo) |=> {cnt_hi, cnt_lo} == 16'h0000)
        else $error("wide counter not cleared on match");
    a_cascade_count: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (!mode8 && lo_wrap && !lo_clr && !wr_cnt_lo) |=> cnt_hi == 8'($past(cnt_hi) + 8'h01))
        else $error("upper half did not follow lower wrap");
    a_latched_commit: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (!mode8 && wr_cnt_lo) |=> cnt_hi == $past(temp_ff) && cnt_lo == $past(bus_req_i.wdata))
        else $error("wide write did not commit both bytes");
    a_flag_one_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (wr_flags && !flags_ff[FLG_UPPER_OVF] && !hi_ov) |=> !flags_ff[FLG_UPPER_OVF])
        else $error("software set a status flag");
endmodule

// *** sim/cmt_cpu_model.sv ***
`timescale 1ns/1ps
// Behavioural CPU on the 8-bit peripheral bus; each strobe lasts one cycle.
module cmt_cpu_model (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output cmt_pkg::cmt_bus_req_s bus_o
);
    import cmt_pkg::*;

    // The bus starts idle so the timer never sees a stray strobe.
    initial bus_o = '0;

    // Write: raised after an edge, dropped after the taking edge; address and data are then scrambled.
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i) #1 bus_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_i) #1 bus_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    // Read: the answer is taken just after the taking edge, once the registered data has settled.
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_i) #1 bus_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_i) #1 bus_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
        d = rdata_i;
    endtask

    task automatic wr16(input logic [15:0] a_hi, input logic [15:0] v);
        wr(a_hi, v[15:8]);
        wr(a_hi + 16'h0001, v[7:0]);
    endtask

    // Read before clearing.
    // Only flags seen as one are cleared, which is why the read must come first.
    task automatic clr_flags(input logic [7:0] keep);
        logic [7:0] d;
        rd(ADDR_FLAGS, d);
        wr(ADDR_FLAGS, d & keep);
    endtask

    // Pin function fixed.
    // The event pin is a dedicated input here, so its function is never switched.
endmodule

// *** sim/test_cmt_timer.sv ***
`timescale 1ns/1ps
// Self-checking bench for the compare-match timer.
module test_cmt_timer;
    import cmt_pkg::*;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic ev_pin = 1'b0;
    logic ev_rise = 1'b1;
    cmt_bus_req_s bus;
    logic [7:0] rdata;
    logic [7:0] d;
    logic up_pin, lo_pin, up_irq, lo_irq, up_pin_d, lo_pin_d;
    int err_count = 0;
    int checked = 0;
    int cyc = 0;
    int up_n = 0, lo_n = 0, up_tog = 0, lo_tog = 0, up_last = 0, up_prev = 0, lo_last = 0, lo_prev = 0;

    cmt_timer cmt_timer_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .bus_req_i(bus), .event_count_pin_i(ev_pin),
        .event_edge_select_i(ev_rise), .rdata_o(rdata), .upper_toggle_pin_o(up_pin),
        .lower_toggle_pin_o(lo_pin), .upper_irq_request_o(up_irq), .lower_irq_request_o(lo_irq));
    cmt_cpu_model cmt_cpu_model_i (.clk_i(clk_i), .rdata_i(rdata), .bus_o(bus));

    // A 100 MHz system clock.
    initial forever #5 clk_i = ~clk_i;

    // Request pulses and pin edges are logged per half for the period checks.
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        up_pin_d <= up_pin;
        lo_pin_d <= lo_pin;
        if (up_pin !== up_pin_d) up_tog <= up_tog + 1;
        if (lo_pin !== lo_pin_d) lo_tog <= lo_tog + 1;
        if (up_irq === 1'b1) begin
            up_n <= up_n + 1;
            up_prev <= up_last;
            up_last <= cyc;
        end
        if (lo_irq === 1'b1) begin
            lo_n <= lo_n + 1;
            lo_prev <= lo_last;
            lo_last <= cyc;
        end
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk32(input int got, input int exp, input string what);
        checked++;
        if (got != exp) begin
            err_count++;
            $display("[ERR] %0t %s got %0d exp %0d", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        cmt_cpu_model_i.wr(a, v);
    endtask

    task automatic rchk(input logic [15:0] a, input logic [7:0] exp, input string what);
        cmt_cpu_model_i.rd(a, d);
        chk8(d, exp, what);
    endtask

    // Each edge is held long enough to pass the synchroniser.
    task automatic ev_set(input logic lvl);
        @(posedge clk_i) #1 ev_pin = lvl;
        repeat (6) @(posedge clk_i);
    endtask

    // Match-to-match period with clear on match: compare value plus one ticks of the tap.
    function automatic int period(input int n, input logic [1:0] s);
        int div;
        case (s)
            2'h0: div = 32;
            2'h1: div = 16;
            2'h2: div = 4;
            default: div = 2;
        endcase
        return (n + 1) * div;
    endfunction

    task automatic end_sim();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // The whole run needs a few thousand cycles; this limit only catches a hang.
    initial begin
        repeat (50000) @(posedge clk_i);
        err_count++;
        end_sim();
    end

    initial begin
        int n_lo, n_up, a0, b0, c0, e0;
        logic [1:0] s;
        d = 8'($urandom(32'hB3716888));
        repeat (20) @(posedge clk_i);
        #1 arst_n_i = 1'b1;
        chk8({6'h00, up_pin, lo_pin}, 8'h00, "pins at reset");
        rchk(ADDR_CNT_HI, 8'h00, "cnt hi");
        rchk(ADDR_CNT_LO, 8'h00, "cnt lo");
        rchk(ADDR_CMP_HI, 8'hFF, "cmp hi");
        rchk(ADDR_CMP_LO, 8'hFF, "cmp lo");
        rchk(ADDR_CTRL, CTRL_READ_VALUE, "ctrl read");
        rchk(16'hFFC0, UNMAPPED_READ_VALUE, "unmapped");
        wr(ADDR_CTRL, 8'h88);
        chk8({6'h00, up_pin, lo_pin}, 8'h03, "levels");
        wr(ADDR_CTRL, 8'h08);
        chk8({6'h00, up_pin, lo_pin}, 8'h01, "levels");
        // Wide mode counting events; the upper select bits 5..4 are set to show they are ignored.
        wr(ADDR_CTRL, 8'h30);
        wr(ADDR_FLAGS, 8'h20);
        cmt_cpu_model_i.wr16(ADDR_CNT_HI, 16'hFFFE);
        a0 = up_n;
        b0 = lo_n;
        c0 = up_tog;
        ev_set(1'b1);
        ev_set(1'b0);
        rchk(ADDR_CNT_HI, 8'hFF, "wide hi");
        rchk(ADDR_CNT_LO, 8'hFF, "wide lo");
        @(posedge clk_i) #1 ev_rise = 1'b0;
        ev_set(1'b1);
        ev_set(1'b0);
        rchk(ADDR_CNT_HI, 8'h00, "wrap hi");
        rchk(ADDR_CNT_LO, 8'h00, "wrap lo");
        rchk(ADDR_FLAGS, 8'hE0, "wide flags");
        chk32(up_n - a0, 2, "upper requests");
        chk32(lo_n - b0, 0, "lower requests");
        chk32(up_tog - c0, 1, "wide toggle");
        cmt_cpu_model_i.clr_flags(8'h33);
        rchk(ADDR_FLAGS, 8'h20, "cleared");
        wr(ADDR_FLAGS, 8'hFF);
        rchk(ADDR_FLAGS, 8'h33, "ones ignored");
        // Wide clear on match: compare 0003 on the /2 tap, with clear enabled by the write above.
        // Without the clear the next wide match would be 65536 ticks away, so the period check trips.
        cmt_cpu_model_i.wr16(ADDR_CMP_HI, 16'h0003);
        cmt_cpu_model_i.wr16(ADDR_CNT_HI, 16'h0000);
        wr(ADDR_CTRL, 8'h07);
        repeat (100) @(posedge clk_i);
        #1;
        chk32(up_last - up_prev, period(3, 2'h3), "wide clear period");
        rchk(ADDR_CMP_HI, 8'h00, "wide cmp hi");
        rchk(ADDR_CMP_LO, 8'h03, "wide cmp lo");
        // Byte mode: both halves on the same tap, each with its own random compare value.
        for (int i = 0; i < 4; i++) begin
            s = i[1:0];
            n_lo = 1 + $urandom % 7;
            n_up = 1 + $urandom % 7;
            wr(ADDR_CTRL, {2'b01, s, 2'b01, s});
            wr(ADDR_FLAGS, 8'h11);
            wr(ADDR_CMP_HI, n_up[7:0]);
            wr(ADDR_CMP_LO, n_lo[7:0]);
            wr(ADDR_CNT_HI, 8'h00);
            wr(ADDR_CNT_LO, 8'h00);
            a0 = up_n;
            b0 = lo_n;
            c0 = up_tog;
            e0 = lo_tog;
            repeat (800) @(posedge clk_i);
            #1;
            chk32(up_last - up_prev, period(n_up, s), "up period");
            chk32(lo_last - lo_prev, period(n_lo, s), "lo period");
            chk32(up_tog - c0, up_n - a0, "up toggles");
            chk32(lo_tog - e0, lo_n - b0, "lo toggles");
        end
        // Lower byte overflow with its request enabled and clear off.
        wr(ADDR_CTRL, 8'h47);
        wr(ADDR_FLAGS, 8'h02);
        wr(ADDR_CMP_LO, 8'h80);
        wr(ADDR_CNT_LO, 8'hFE);
        // Taken after the load, so a late match request from the old compare value is not counted.
        b0 = lo_n;
        repeat (20) @(posedge clk_i);
        cmt_cpu_model_i.rd(ADDR_FLAGS, d);
        chk8(d & 8'h0F, 8'h0E, "lo flags");
        chk32(lo_n - b0, 1, "lo overflow");
        end_sim();
    end
endmodule
